// >>> verilog/vc_arb_regs_defs.vh
// constants for the channel arbitration status and capability registers
`ifndef VC_ARB_REGS_DEFS_VH
`define VC_ARB_REGS_DEFS_VH

// bus geometry
`define ADDR_W 12
`define DATA_W 32
`define STRB_W 4
`define WORD_LSB 2

// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STAT 12'h004
`define OFF_CAP 12'h008
`define OFF_RSEL 12'h00C
// weight table window, one word per entry
`define OFF_TBL 12'h100
`define TBL_AW 4
`define TBL_DEPTH 16
`define TBL_LAST 4'hF
`define TBL_HI_MSB 11
`define TBL_HI_LSB 6

// port_channel_control fields
`define LOAD_REQ_BIT 0
`define SEL_MSB 3
`define SEL_LSB 1
`define SEL_W 3
`define SEL_RST 3'h0

// port_channel_status fields
`define PEND_BIT 0
`define PEND_RST 1'b0

// channel_resource_capability fields
`define CAP_MSB 7
`define CAP_LSB 0
`define CAP_W 8
`define UNDEF_BIT 14
// bits 6-7 of the support field are reserved
`define CAP_RSVD_MASK 8'h3F
// support field value of this resource, all six schemes offered
`define CAP_SUPPORT 8'h3F
// value driven on the legacy bit, arbitrary
`define UNDEF_VAL 1'b0

// resource scheme select register
`define RSEL_MSB 2
`define RSEL_W 3
`define RSEL_RST 3'h0

// responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define ZERO32 32'h00000000

`endif

// >>> verilog/weight_table_mem.v
// weight table storage: byte-lane write port, registered read port
`timescale 1ns/10ps
`default_nettype none
`include "vc_arb_regs_defs.vh"

module weight_table_mem (
    input wire clk,
    input wire wr_en,
    input wire [`STRB_W-1:0] wr_strb,
    input wire [`TBL_AW-1:0] wr_addr,
    input wire [`DATA_W-1:0] wr_data,
    input wire rd_en,
    input wire [`TBL_AW-1:0] rd_addr,
    output reg [`DATA_W-1:0] rd_data
);
    reg [`DATA_W-1:0] mem [0:`TBL_DEPTH-1];
    integer i;

    // write each enabled byte lane; no reset, contents are software's
    always @(posedge clk) begin
        if (wr_en) begin
            for (i = 0; i < `STRB_W; i = i + 1) begin
                if (wr_strb[i]) begin
                    mem[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
                end
            end
        end
    end

    // read data from a register, one cycle after rd_en
    always @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // weight_table_mem

`default_nettype wire

// >>> verilog/vc_arb_status_capability_regs.v
// axi4-lite register bank: table status, load, capability, weight table
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "vc_arb_regs_defs.vh"

// Summary of operation
// - any weight table write sets the table-pending flag, status bit 0
// - flag clears once loading finishes after a table-load request, unless the table was written during the walk
// - flag resets to 0; meaningful only when the scheme uses the table
// - capability bits 7:0 hold the read-only scheme support field
// - bits 0..5 name rr, wrr32/64/128, time wrr128, wrr256; 6-7 reserved
// - with several support bits, resource selectable to any advertised one
// - support field meaningful for switch, p2p root and root_register_block
// - capability bit 14 read-only undefined; software ignores it
// - table_load_request bit always reads back 0
module vc_arb_status_capability_regs (
    input wire clk,
    input wire reset_n,
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [`DATA_W-1:0] s_axi_wdata,
    input wire [`STRB_W-1:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [`DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [`SEL_W-1:0] channel_arb_select,
    output reg [`RSEL_W-1:0] port_arb_select,
    output reg table_pending_flag,
    output reg table_latch_valid,
    output reg [`TBL_AW-1:0] table_latch_index,
    output wire [`DATA_W-1:0] table_latch_data
);
    // held write address and data, taken in either order
    reg aw_held_r;
    reg [`ADDR_W-1:0] awaddr_r;
    reg w_held_r;
    reg [`DATA_W-1:0] wdata_r;
    reg [`STRB_W-1:0] wstrb_r;
    // read side
    reg rd_mem_r;
    // loader
    reg ld_active_r;
    reg [`TBL_AW-1:0] ld_idx_r;
    reg dirty_r;

    wire do_wr;
    wire wr_tbl;
    wire wr_ctrl;
    wire wr_rsel;
    wire load_start;
    wire ld_done;
    wire ar_fire;
    wire ar_tbl;
    wire mem_rd_en;
    wire [`TBL_AW-1:0] mem_rd_addr;
    wire [`DATA_W-1:0] mem_q;
    wire [`RSEL_W-1:0] rsel_wr;
    wire [`CAP_W-1:0] cap_field;
    reg [`DATA_W-1:0] reg_rd_val;
    reg reg_rd_hit;

    // true when the word address falls in the weight table window
    function is_table;
        input [`ADDR_W-1:0] a;
        reg [`ADDR_W-1:0] base;
        begin
            // same slice of the window base, so both sides match in width
            base = `OFF_TBL;
            is_table = (a[`TBL_HI_MSB:`TBL_HI_LSB] ==
                        base[`TBL_HI_MSB:`TBL_HI_LSB]);
        end
    endfunction

    // table entry index from a byte address
    function [`TBL_AW-1:0] tbl_index;
        input [`ADDR_W-1:0] a;
        begin
            tbl_index = a[`WORD_LSB +: `TBL_AW];
        end
    endfunction

    // word-aligned compare, low address bits ignored
    function addr_is;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] off;
        begin
            addr_is = (a[`ADDR_W-1:`WORD_LSB] == off[`ADDR_W-1:`WORD_LSB]);
        end
    endfunction

    // no port-type input: the field reads alike wherever the block sits
    // field always driven
    // reserved support bits forced to zero
    assign cap_field = `CAP_SUPPORT & `CAP_RSVD_MASK;

    // write channel handshakes: each side is free until its item is held
    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready = ~w_held_r;
    assign do_wr = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign wr_tbl = do_wr & is_table(awaddr_r);
    assign wr_ctrl = do_wr & addr_is(awaddr_r, `OFF_CTRL) & wstrb_r[0];
    assign wr_rsel = do_wr & addr_is(awaddr_r, `OFF_RSEL) & wstrb_r[0];
    // only a written 1 requests a load; 0 is a no-op
    assign load_start = wr_ctrl & wdata_r[`LOAD_REQ_BIT];
    assign rsel_wr = wdata_r[`RSEL_MSB:0];

    // capture address and data independently
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_r <= 1'b0;
            awaddr_r <= {`ADDR_W{1'b0}};
            w_held_r <= 1'b0;
            wdata_r <= `ZERO32;
            wstrb_r <= {`STRB_W{1'b0}};
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (do_wr) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // write response; unmapped offsets answer slverr
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            if (is_table(awaddr_r) || addr_is(awaddr_r, `OFF_CTRL) ||
                addr_is(awaddr_r, `OFF_STAT) ||
                addr_is(awaddr_r, `OFF_CAP) ||
                addr_is(awaddr_r, `OFF_RSEL)) begin
                s_axi_bresp <= `RESP_OKAY;
            end else begin
                s_axi_bresp <= `RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // writable control fields; status and capability writes fall away
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_arb_select <= `SEL_RST;
            port_arb_select <= `RSEL_RST;
        end else begin
            if (wr_ctrl) begin
                channel_arb_select <= wdata_r[`SEL_MSB:`SEL_LSB];
            end
            // any advertised scheme may be chosen; others refused
            // a 3-bit select always lands inside the 8-bit field
            if (wr_rsel && cap_field[rsel_wr]) begin
                port_arb_select <= rsel_wr;
            end
        end
    end

    // loader walks every entry once, one per cycle, after a request.
    // a new request restarts the walk so the latest values win.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ld_active_r <= 1'b0;
            ld_idx_r <= {`TBL_AW{1'b0}};
        end else if (load_start) begin
            ld_active_r <= 1'b1;
            ld_idx_r <= {`TBL_AW{1'b0}};
        end else if (ld_active_r) begin
            ld_idx_r <= ld_idx_r + 1'b1;
            if (ld_idx_r == `TBL_LAST) begin
                ld_active_r <= 1'b0;
            end
        end
    end

    // latch strobe follows each loader read by one cycle, except a read cut off by a new request
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            table_latch_valid <= 1'b0;
            table_latch_index <= {`TBL_AW{1'b0}};
        end else begin
            table_latch_valid <= ld_active_r & ~load_start;
            table_latch_index <= ld_idx_r;
        end
    end
    assign table_latch_data = mem_q;
    assign ld_done = table_latch_valid & (table_latch_index == `TBL_LAST)
                     & ~ld_active_r;

    // table write during a walk may be missed by it, so remember it
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dirty_r <= 1'b0;
        end else if (load_start) begin
            dirty_r <= 1'b0;
        end else if (wr_tbl && (ld_active_r || table_latch_valid)) begin
            dirty_r <= 1'b1;
        end
    end

    // reported under every scheme; whether it matters is software's call
    // flag resets to 0
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            table_pending_flag <= `PEND_RST;
        end else if (wr_tbl) begin
            table_pending_flag <= 1'b1;
        end else if (ld_done && !dirty_r) begin
            table_pending_flag <= 1'b0;
        end
    end

    // loader owns the read port; a table read waits in arready meanwhile
    assign ar_tbl = is_table(s_axi_araddr);
    assign s_axi_arready = ~s_axi_rvalid & ~rd_mem_r &
                           ~(ar_tbl & (ld_active_r | load_start));
    assign ar_fire = s_axi_arvalid & s_axi_arready;
    assign mem_rd_en = ld_active_r | (ar_fire & ar_tbl);
    assign mem_rd_addr = ld_active_r ? ld_idx_r : tbl_index(s_axi_araddr);

    weight_table_mem u_table (
        .clk(clk),
        .wr_en(wr_tbl),
        .wr_strb(wstrb_r),
        .wr_addr(tbl_index(awaddr_r)),
        .wr_data(wdata_r),
        .rd_en(mem_rd_en),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_q)
    );

    // register read mux
    always @* begin
        reg_rd_val = `ZERO32;
        reg_rd_hit = 1'b1;
        if (addr_is(s_axi_araddr, `OFF_CTRL)) begin
            reg_rd_val[`LOAD_REQ_BIT] = 1'b0;
            reg_rd_val[`SEL_MSB:`SEL_LSB] = channel_arb_select;
        end else if (addr_is(s_axi_araddr, `OFF_STAT)) begin
            reg_rd_val[`PEND_BIT] = table_pending_flag;
        end else if (addr_is(s_axi_araddr, `OFF_CAP)) begin
            reg_rd_val[`CAP_MSB:`CAP_LSB] = cap_field;
            reg_rd_val[`UNDEF_BIT] = `UNDEF_VAL;
        end else if (addr_is(s_axi_araddr, `OFF_RSEL)) begin
            reg_rd_val[`RSEL_MSB:0] = port_arb_select;
        end else begin
            reg_rd_hit = 1'b0;
        end
    end

    // read answer: registers next cycle, table entries one cycle later
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_mem_r <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `ZERO32;
            s_axi_rresp <= `RESP_OKAY;
        end else if (ar_fire && ar_tbl) begin
            rd_mem_r <= 1'b1;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= reg_rd_val;
            s_axi_rresp <= reg_rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rd_mem_r) begin
            rd_mem_r <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= mem_q;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // vc_arb_status_capability_regs

`default_nettype wire

// >>> tb/vc_arb_regs_checker.sv
// concurrent checks on the channel arbitration register bank ports
`timescale 1ns/10ps
`default_nettype none
module vc_arb_regs_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic table_pending_flag,
    input wire logic table_latch_valid,
    input wire logic [3:0] table_latch_index
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // both write channels taken at one edge, whether or not an answer is pending
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence walk_last;
        table_latch_valid && table_latch_index == 4'hF;
    endsequence
    // bus answers at the handed-over latency
    a_wr_answer: assert property (wr_take and !s_axi_bvalid
        |-> ##2 s_axi_bvalid) else $error("write answer not on time");
    a_rd_answer: assert property (rd_take |-> ##[1:2] s_axi_rvalid)
        else $error("read answer not on time");
    a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer stands");
    // reset level holds even while the reset itself is low
    a_pend_reset: assert property (disable iff (1'b0)
        !reset_n |-> !table_pending_flag) else $error("pending set in reset");
    a_pend_rise: assert property ($rose(table_pending_flag)
        |-> $rose(s_axi_bvalid)) else $error("pending set without a write");
    a_pend_fall: assert property ($fell(table_pending_flag)
        |-> $past(table_latch_valid) && $past(table_latch_index) == 4'hF)
        else $error("pending cleared before the walk ended");
    a_walk_start: assert property ($rose(table_latch_valid)
        |-> table_latch_index == 4'h0) else $error("walk not starting at 0");
    a_walk_step: assert property (table_latch_valid
        && table_latch_index != 4'hF |=> table_latch_valid
        && table_latch_index == $past(table_latch_index) + 4'h1)
        else $error("walk skipped an entry");
    a_walk_end: assert property (walk_last |=> !table_latch_valid)
        else $error("walk ran past the last entry");
endmodule // vc_arb_regs_checker
bind vc_arb_status_capability_regs
    vc_arb_regs_checker u_vc_arb_regs_checker (.*);
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the channel arbitration register bank
`timescale 1ns/10ps
`default_nettype none
`include "vc_arb_regs_defs.vh"
module tb_top;
    logic clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic table_pending_flag, table_latch_valid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, table_latch_data, d;
    logic [3:0] s_axi_wstrb, table_latch_index;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] channel_arb_select, port_arb_select, sel, ps;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [31:0] tbl[16];
    integer seed = 32'hCC8EF68D;
    int error_cnt, checks, cyc, lc, i;
    localparam logic [31:0] CAPV = {17'h0, `UNDEF_VAL, 6'h0,
        `CAP_SUPPORT & `CAP_RSVD_MASK};
    vc_arb_status_capability_regs u_vc_arb_status_capability_regs (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input [33:0] v, input [33:0] e);
        checks++;
        if (v !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, v, e);
        end
    endtask
    task complete_run;
        $display("mismatches %0d compares %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // address and data offered together, each released when taken
    task wr(input [11:0] a, input [31:0] v, input [3:0] s, input [1:0] e);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        bq.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
        end
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input [11:0] a, input [31:0] v, input [1:0] e);
        @(posedge clk);
        rq.push_back({v, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    task rs(input logic p);
        rd(`OFF_STAT, {31'h0, p}, `RESP_OKAY);
    endtask
    // scoreboard side: oldest note against each answer, plus hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run;
        end
        if (s_axi_bvalid && s_axi_bready)
            chk(s_axi_bresp, bq.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rdata, s_axi_rresp}, rq.pop_front());
        if (table_latch_valid) begin
            chk(table_latch_data, tbl[table_latch_index]);
            lc++;
        end
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 29'h0;
        s_axi_wdata = 32'h0;
        // a step off time 0 so every reset process sees the falling edge
        #1 reset_n = 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rs(1'b0);
        rd(`OFF_CAP, CAPV, `RESP_OKAY);
        // read-only places swallow random writes
        wr(`OFF_STAT, $random(seed), 4'hF, `RESP_OKAY);
        wr(`OFF_CAP, $random(seed), 4'hF, `RESP_OKAY);
        rs(1'b0);
        rd(`OFF_CAP, CAPV, `RESP_OKAY);
        // fill every entry; unwritten words are unknown in memory
        for (i = 0; i < 16; i++) begin
            tbl[i] = $random(seed);
            wr(`OFF_TBL | {6'h0, i[3:0], 2'h0}, tbl[i], 4'hF, `RESP_OKAY);
            if (i == 0) rs(1'b1);
        end
        d = $random(seed);
        tbl[5][15:0] = d[15:0];
        wr(`OFF_TBL | 12'h014, d, 4'h3, `RESP_OKAY);
        for (i = 0; i < 16; i++)
            rd(`OFF_TBL | {6'h0, i[3:0], 2'h0}, tbl[i], `RESP_OKAY);
        sel = $random(seed);
        wr(`OFF_CTRL, {28'h0, sel, 1'b0}, 4'h1, `RESP_OKAY);
        rs(1'b1);
        rd(`OFF_CTRL, {28'h0, sel, 1'b0}, `RESP_OKAY);
        chk(channel_arb_select, sel);
        // load walk: pending stays up until the last entry is latched
        wr(`OFF_CTRL, {28'h0, sel, 1'b1}, 4'h1, `RESP_OKAY);
        rs(1'b1);
        rd(`OFF_CTRL, {28'h0, sel, 1'b0}, `RESP_OKAY);
        repeat (24) @(posedge clk);
        rs(1'b0);
        chk(lc, 16);
        // table write inside a walk keeps the flag up for another load
        wr(`OFF_CTRL, {28'h0, sel, 1'b1}, 4'h1, `RESP_OKAY);
        wr(`OFF_TBL | 12'h03C, tbl[15], 4'hF, `RESP_OKAY);
        repeat (24) @(posedge clk);
        rs(1'b1);
        wr(`OFF_CTRL, {28'h0, sel, 1'b1}, 4'h1, `RESP_OKAY);
        repeat (24) @(posedge clk);
        rs(1'b0);
        chk(lc, 48);
        // only advertised schemes may be chosen
        ps = `RSEL_RST;
        for (i = 0; i < 8; i++) begin
            d = {$random(seed)} & 32'hFFFFFFF8 | i;
            wr(`OFF_RSEL, d, 4'h1, `RESP_OKAY);
            if (((`CAP_SUPPORT & `CAP_RSVD_MASK) >> i) & 1) ps = i[2:0];
            rd(`OFF_RSEL, {29'h0, ps}, `RESP_OKAY);
            chk(port_arb_select, ps);
        end
        for (i = 0; i < 2; i++) begin
            wr(i ? 12'h140 : 12'h010, $random(seed), 4'hF, `RESP_SLVERR);
            rd(i ? 12'h140 : 12'h010, 32'h0, `RESP_SLVERR);
        end
        // second reset with the flag raised
        wr(`OFF_TBL, tbl[0], 4'hF, `RESP_OKAY);
        rs(1'b1);
        reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rs(1'b0);
        rd(`OFF_CTRL, {28'h0, `SEL_RST, 1'b0}, `RESP_OKAY);
        complete_run;
    end
endmodule // tb_top
`default_nettype wire
